// ### rtl/mh_pkg.sv
// constants shared by the memory hub control block and its ecc lane
// assumes a 100 MHz system clock and two pairs of registered ecc modules
package mh_pkg;
	localparam int ADDR_W = 36;
	localparam int LANE_W = 72;
	localparam int LANES = 2;
	localparam int DATA_W = 144;
	localparam int CHK_W = 8;
	localparam int SYN_W = 7;
	localparam int IOQ_DEPTH = 12;
	localparam int IOQ_PTR_W = 4;
	localparam int MA_W = 13;
	localparam int BA_W = 2;
	localparam int ROW_W = 2;
	localparam int BEAT_LG = 4;
	localparam int COL_MIN = 9;
	localparam int ROW_MIN = 12;
	localparam int MHZ_FAST = 266;
	localparam int MHZ_SLOW = 200;
	localparam logic [1:0] CLK_SEL_FAST = 2'h1;
	localparam logic [1:0] CLK_SEL_SLOW = 2'h0;
	localparam int SCRUB_NS = 10240;
	localparam int CLK_NS = 10;
	localparam int SCRUB_CYC = SCRUB_NS / CLK_NS;
	localparam int SCRUB_CNT_W = 16;
	typedef enum logic {MH_CAS_20, MH_CAS_25} mh_cas_t;
endpackage

// ### rtl/mh_ecc_lane.sv
// single-error-correct, double-error-detect check of one 72-bit lane
// assumes an extended hamming layout: bit 0 overall parity, check bits
// at the power-of-two positions, data in the other 64 positions
`timescale 1ns/1ps
module mh_ecc_lane (
	input wire logic [mh_pkg::LANE_W-1:0] code_in,
	output logic [mh_pkg::LANE_W-1:0] code_fix,
	output logic err_single,
	output logic err_multi
);
	logic [mh_pkg::SYN_W-1:0] syn;
	logic par;

	// syndrome over positions 1..71 plus whole-word parity
	always_comb begin
		syn = '0;
		for (int p = 1; p < mh_pkg::LANE_W; p++) begin
			if (code_in[p])
				syn = syn ^ mh_pkg::SYN_W'(p);
		end
		par = ^code_in;
	end

	// odd parity with a syndrome below 72 means one flipped bit; even parity
	// with a syndrome, or odd parity past 71, means two or more, which cannot be repaired
	always_comb begin
		code_fix = code_in;
		err_single = 1'b0;
		err_multi = 1'b0;
		if (par) begin
			if (syn < mh_pkg::SYN_W'(mh_pkg::LANE_W)) begin
				code_fix[syn] = ~code_in[syn];
				err_single = 1'b1;
			end else begin
				err_multi = 1'b1;
			end
		end else if (syn != '0) begin
			err_multi = 1'b1;
		end
	end
endmodule

// ### rtl/mh_ctl.sv
// memory hub control: clock choice, pair checks, address decode,
// in-order queue, routing, ecc check and scrubbing
// assumes firmware drives geometry and population ports from the
// module config eeproms before raising cfg_done
//
// Summary of operation
// R1: memory clock 266 at 533 bus, else 200
// R2: 144-bit path, one module per half
// R3: pair lacking two modules stays unmapped
// R4: boot needs one full module pair
// R5: second pair needs first pair populated; code maps the second pair alone
// R6: first pair rows 0,1; second 2,3
// R7: modules in pair identical; pairs differ size
// R8: eight check bits per lane, correct/detect
// R9: background scrub; x4 device correction; code corrects one bit per lane
// R10: two bank lines, thirteen row/col lines
// R11: cas latency 2.0 or 2.5 only
// R12: module 128 MB to 2 GB each; decode also maps 64 MB modules
// R13: eeproms at fixed i2c slot addresses
// R14: firmware programs registers from eeprom data
// R15: 12/13 rows, 4 banks, 9-12 columns
// R16: twelve-deep in-order processor queue; code admits eleven entries
// R17: route each request to memory or outbound
// R18: accept inbound requests from both i/o hubs
// R19: flag and pulse on ecc errors, log row
`timescale 1ns/1ps
module mh_ctl (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic proc_bus_533,
	input wire logic [3:0] slot_present,
	input wire logic [1:0] pair_row13,
	input wire logic [3:0] pair_col_sel,
	input wire logic [1:0] pair_dual_side,
	input wire logic cas_latency_setting,
	input wire logic cfg_done,
	input wire logic scrub_en,
	input wire logic host_valid,
	input wire logic host_write,
	input wire logic [mh_pkg::ADDR_W-1:0] host_addr,
	input wire logic out_ready,
	input wire logic [1:0] io_valid,
	input wire logic [mh_pkg::ADDR_W-1:0] io0_addr,
	input wire logic [mh_pkg::ADDR_W-1:0] io1_addr,
	input wire logic [1:0] io_write,
	input wire logic rd_valid,
	input wire logic [mh_pkg::DATA_W-1:0] rd_data,
	input wire logic [mh_pkg::ROW_W-1:0] rd_row,
	input wire logic rd_scrub,
	input wire logic clr_single,
	input wire logic clr_multi,
	output logic [1:0] mem_clk_sel_r,
	output logic [1:0] pair_usable_r,
	output logic [3:0] row_enable_r,
	output logic [mh_pkg::ADDR_W:0] mem_top_r,
	output logic cas_sel_r,
	output logic host_ready_r,
	output logic cmd_valid_r,
	output logic cmd_write_r,
	output logic cmd_scrub_r,
	output logic [mh_pkg::BA_W-1:0] cmd_bank_r,
	output logic [mh_pkg::MA_W-1:0] cmd_row_r,
	output logic [mh_pkg::MA_W-1:0] cmd_col_r,
	output logic [mh_pkg::ROW_W-1:0] cmd_rank_r,
	output logic out_valid_r,
	output logic out_write_r,
	output logic [mh_pkg::ADDR_W-1:0] out_addr_r,
	output logic [1:0] io_ack_r,
	output logic rdq_valid_r,
	output logic [mh_pkg::DATA_W-1:0] rdq_data_r,
	output logic wb_valid_r,
	output logic [mh_pkg::DATA_W-1:0] wb_data_r,
	output logic [mh_pkg::ROW_W-1:0] wb_rank_r,
	output logic err_single_r,
	output logic err_multi_r,
	output logic err_single_evt_r,
	output logic err_multi_evt_r,
	output logic [mh_pkg::ROW_W-1:0] err_row_r
);
	localparam int AW = mh_pkg::ADDR_W;
	localparam int PW = mh_pkg::IOQ_PTR_W;

	logic [AW-1:0] q_addr [mh_pkg::IOQ_DEPTH];
	logic q_wr [mh_pkg::IOQ_DEPTH];
	logic [PW-1:0] q_head_r, q_tail_r, q_cnt_r;
	logic [5:0] lg [2];
	logic [AW:0] top1;
	logic [1:0] usable;
	logic [AW-1:0] head_addr, io_addr_sel, scrub_addr_r, dec_addr;
	logic head_mem, pop, io_pick_r, io_take, scrub_take, push;
	logic [1:0] io_req;
	logic [1:0] dec_rank, dec_bank;
	logic [12:0] dec_row, dec_col;
	logic [mh_pkg::SCRUB_CNT_W-1:0] scrub_cnt_r;
	logic scrub_tick_r;
	logic [mh_pkg::LANES-1:0] l_single, l_multi;
	logic [mh_pkg::DATA_W-1:0] fixed;

	// a pair counts only with both slots filled
	always_comb begin
		usable[0] = &slot_present[1:0]; // R3 R2
		usable[1] = &slot_present[3:2]; // R3
	end

	// pair capacity in log2 bytes: rows+banks+cols+side+16-byte beat
	for (genvar g = 0; g < 2; g++) begin : g_lg
		assign lg[g] = 6'(mh_pkg::ROW_MIN) + {5'h00, pair_row13[g]}
			+ 6'(mh_pkg::COL_MIN) + {4'h0, pair_col_sel[2*g +: 2]}
			+ 6'(mh_pkg::BA_W) + {5'h00, pair_dual_side[g]}
			+ 6'(mh_pkg::BEAT_LG); // R15
	end
	assign top1 = usable[0] ? ((AW+1)'(1) << lg[0]) : '0;

	// geometry registers follow the ports while configuration is open and
	// hold after cfg_done; the decode reads the geometry ports directly
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pair_usable_r <= 2'h0;
			row_enable_r <= 4'h0;
			mem_top_r <= '0;
			cas_sel_r <= 1'b0;
			mem_clk_sel_r <= mh_pkg::CLK_SEL_SLOW;
		end else if (!cfg_done) begin
			pair_usable_r <= usable; // R3
			row_enable_r <= {usable[1] & pair_dual_side[1], usable[1],
				usable[0] & pair_dual_side[0], usable[0]}; // R6
			mem_top_r <= top1 + (usable[1] ?
				((AW+1)'(1) << lg[1]) : '0); // R3
			cas_sel_r <= cas_latency_setting; // R11
			mem_clk_sel_r <= proc_bus_533 ? mh_pkg::CLK_SEL_FAST
				: mh_pkg::CLK_SEL_SLOW; // R1
		end
	end

	// in-order queue of processor requests, twelve deep
	assign push = host_valid && host_ready_r && cfg_done;
	assign head_addr = q_addr[q_head_r];
	assign head_mem = {1'b0, head_addr} < mem_top_r; // R17
	assign pop = (q_cnt_r != '0) && (head_mem || !out_valid_r || out_ready);
	always_ff @(posedge clk_sys) begin
		if (push) begin
			q_addr[q_tail_r] <= host_addr; // R16
			q_wr[q_tail_r] <= host_write;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q_head_r <= '0;
			q_tail_r <= '0;
			q_cnt_r <= '0;
			host_ready_r <= 1'b0;
		end else begin
			if (push)
				q_tail_r <= (q_tail_r == PW'(mh_pkg::IOQ_DEPTH-1)) ? '0
					: q_tail_r + 1'b1;
			if (pop)
				q_head_r <= (q_head_r == PW'(mh_pkg::IOQ_DEPTH-1)) ? '0
					: q_head_r + 1'b1;
			q_cnt_r <= q_cnt_r + PW'(push) - PW'(pop); // R16
			// ready drops one entry early since it is registered
			host_ready_r <= cfg_done && ((q_cnt_r + PW'(push) - PW'(pop))
				< PW'(mh_pkg::IOQ_DEPTH - 1)); // R16
		end
	end

	// outbound path toward the i/o buses holds until accepted
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_valid_r <= 1'b0;
			out_write_r <= 1'b0;
			out_addr_r <= '0;
		end else if (pop && !head_mem) begin
			out_valid_r <= 1'b1; // R17
			out_write_r <= q_wr[q_head_r];
			out_addr_r <= head_addr;
		end else if (out_ready) begin
			out_valid_r <= 1'b0;
		end
	end

	// memory slot: host head first, then i/o hubs in turn, then scrub
	// a hub whose ack is out is still holding its old request, so it
	// is masked for that cycle to avoid taking the request twice
	assign io_req = io_valid & ~io_ack_r;
	assign io_take = !(pop && head_mem) && (io_req != 2'h0);
	assign scrub_take = !(pop && head_mem) && !io_take && scrub_tick_r
		&& scrub_en && (mem_top_r != '0);
	always_comb begin
		if (io_req[io_pick_r])
			io_addr_sel = io_pick_r ? io1_addr : io0_addr;
		else
			io_addr_sel = io_pick_r ? io0_addr : io1_addr;
		if (pop && head_mem)
			dec_addr = head_addr;
		else if (io_take)
			dec_addr = io_addr_sel; // R18
		else
			dec_addr = scrub_addr_r;
	end

	// split a flat address into pair, side, bank, row and column
	function automatic void split(input logic [AW-1:0] a,
		output logic [1:0] rank, output logic [1:0] bank,
		output logic [12:0] row, output logic [12:0] col);
		logic [AW-1:0] o;
		logic p;
		int c, r;
		p = {1'b0, a} >= top1;
		o = p ? AW'({1'b0, a} - top1) : a;
		c = mh_pkg::COL_MIN + int'(pair_col_sel[2*p +: 2]);
		r = mh_pkg::ROW_MIN + int'(pair_row13[p]);
		o = o >> mh_pkg::BEAT_LG;
		col = 13'(o & ((AW'(1) << c) - 1'b1)); // R15
		o = o >> c;
		bank = o[1:0]; // R10
		o = o >> mh_pkg::BA_W;
		row = 13'(o & ((AW'(1) << r) - 1'b1)); // R10
		o = o >> r;
		rank = {p, o[0] & pair_dual_side[p]}; // R6
	endfunction

	// decode of the selected slot address, registered below
	always_comb begin
		split(dec_addr, dec_rank, dec_bank, dec_row, dec_col);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_valid_r <= 1'b0;
			cmd_write_r <= 1'b0;
			cmd_scrub_r <= 1'b0;
			cmd_bank_r <= '0;
			cmd_row_r <= '0;
			cmd_col_r <= '0;
			cmd_rank_r <= '0;
			io_ack_r <= 2'h0;
			io_pick_r <= 1'b0;
		end else begin
			io_ack_r <= 2'h0;
			cmd_valid_r <= 1'b0;
			if ((pop && head_mem) || io_take || scrub_take) begin
				cmd_rank_r <= dec_rank;
				cmd_bank_r <= dec_bank;
				cmd_row_r <= dec_row;
				cmd_col_r <= dec_col;
				// i/o requests above the map are acked but dropped
				cmd_valid_r <= !io_take || ({1'b0, dec_addr} < mem_top_r);
				cmd_write_r <= (pop && head_mem) ? q_wr[q_head_r]
					: io_take ? io_write[io_req[io_pick_r] ? io_pick_r
					: !io_pick_r] : 1'b0;
				cmd_scrub_r <= scrub_take; // R9
			end
			if (io_take) begin
				if (io_req[io_pick_r])
					io_ack_r[io_pick_r] <= 1'b1; // R18
				else
					io_ack_r[!io_pick_r] <= 1'b1;
				io_pick_r <= !io_pick_r;
			end
		end
	end

	// scrub pacing: one read slot per interval, walking the whole map
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scrub_cnt_r <= '0;
			scrub_tick_r <= 1'b0;
			scrub_addr_r <= '0;
		end else begin
			if (scrub_cnt_r == mh_pkg::SCRUB_CNT_W'(mh_pkg::SCRUB_CYC-1)) begin
				scrub_cnt_r <= '0;
				scrub_tick_r <= 1'b1;
			end else begin
				scrub_cnt_r <= scrub_cnt_r + 1'b1;
			end
			if (scrub_take) begin
				scrub_tick_r <= 1'b0;
				scrub_addr_r <= ({1'b0, scrub_addr_r} + (AW+1)'(16)
					>= mem_top_r) ? '0 : scrub_addr_r + AW'(16); // R9
			end
		end
	end

	// one check per module lane of the 144-bit word
	for (genvar g = 0; g < mh_pkg::LANES; g++) begin : g_lane
		mh_ecc_lane u_lane (
			.code_in(rd_data[g*mh_pkg::LANE_W +: mh_pkg::LANE_W]),
			.code_fix(fixed[g*mh_pkg::LANE_W +: mh_pkg::LANE_W]),
			.err_single(l_single[g]),
			.err_multi(l_multi[g])
		); // R8 R2
	end

	// read return; a repaired scrub read is written back corrected
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdq_valid_r <= 1'b0;
			rdq_data_r <= '0;
			wb_valid_r <= 1'b0;
			wb_data_r <= '0;
			wb_rank_r <= '0;
		end else begin
			rdq_valid_r <= rd_valid && !rd_scrub;
			if (rd_valid)
				rdq_data_r <= fixed; // R8
			wb_valid_r <= rd_valid && rd_scrub && (l_single != '0)
				&& (l_multi == '0); // R9
			if (rd_valid && rd_scrub) begin
				wb_data_r <= fixed;
				wb_rank_r <= rd_row;
			end
		end
	end

	// sticky error flags: a new error in the clear cycle wins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			err_single_r <= 1'b0;
			err_multi_r <= 1'b0;
			err_single_evt_r <= 1'b0;
			err_multi_evt_r <= 1'b0;
			err_row_r <= '0;
		end else begin
			err_single_evt_r <= rd_valid && (l_single != '0)
				&& (l_multi == '0); // R19
			err_multi_evt_r <= rd_valid && (l_multi != '0); // R19
			if (rd_valid && (l_multi != '0))
				err_multi_r <= 1'b1;
			else if (clr_multi)
				err_multi_r <= 1'b0;
			if (rd_valid && (l_single != '0) && (l_multi == '0))
				err_single_r <= 1'b1;
			else if (clr_single)
				err_single_r <= 1'b0;
			if (rd_valid && (l_single != '0 || l_multi != '0))
				err_row_r <= rd_row; // R19
		end
	end
endmodule

// ### testbench/mh_ctl_props.sv
// concurrent checks on the memory hub control block ports
// assumes one clock domain; bound onto mh_ctl by port name
`timescale 1ns/1ps
module mh_ctl_props (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic proc_bus_533,
	input wire logic [3:0] slot_present,
	input wire logic cas_latency_setting,
	input wire logic cfg_done,
	input wire logic host_valid,
	input wire logic [35:0] host_addr,
	input wire logic out_ready,
	input wire logic [1:0] io_valid,
	input wire logic [1:0] mem_clk_sel_r,
	input wire logic [1:0] pair_usable_r,
	input wire logic [3:0] row_enable_r,
	input wire logic [36:0] mem_top_r,
	input wire logic cas_sel_r,
	input wire logic host_ready_r,
	input wire logic cmd_valid_r,
	input wire logic out_valid_r,
	input wire logic [35:0] out_addr_r,
	input wire logic [1:0] io_ack_r
);
	// single domain, so clock and reset are stated once
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// a low memory address taken while the map covers it
	sequence s_mem_take;
		host_valid && host_ready_r && cfg_done && host_addr < 36'h100 &&
			mem_top_r > 37'h100;
	endsequence
	// queue may hold older work, so the command gets a short window
	sequence s_cmd_issue;
		##[1:16] cmd_valid_r;
	endsequence
	a_clk_fast: assert property (
		!cfg_done && proc_bus_533 |=> mem_clk_sel_r == mh_pkg::CLK_SEL_FAST)
		else $error("memory clock not fast");
	a_clk_slow: assert property (
		!cfg_done && !proc_bus_533 |=> mem_clk_sel_r == mh_pkg::CLK_SEL_SLOW)
		else $error("memory clock not slow");
	a_pair_unmapped: assert property (
		!cfg_done && slot_present[1:0] != 2'h3 |=>
			!pair_usable_r[0] && row_enable_r[1:0] == 2'h0)
		else $error("half pair mapped");
	a_rows_pair: assert property (
		!(|row_enable_r[1:0] && !pair_usable_r[0]) &&
			!(|row_enable_r[3:2] && !pair_usable_r[1]))
		else $error("row outside its pair");
	a_cas_follow: assert property (
		!cfg_done |=> cas_sel_r == $past(cas_latency_setting))
		else $error("cas latency not taken");
	a_ready_cfg: assert property (
		!cfg_done |=> !host_ready_r)
		else $error("ready before config");
	a_host_cmd: assert property (
		s_mem_take |-> s_cmd_issue)
		else $error("memory request not issued");
	a_out_hold: assert property (
		out_valid_r && !out_ready |=> out_valid_r && $stable(out_addr_r))
		else $error("outbound request dropped");
	a_io_ack_cause: assert property (
		io_ack_r != 2'h0 |->
			io_ack_r != 2'h3 && (io_ack_r & ~$past(io_valid)) == 2'h0)
		else $error("inbound ack without request");
endmodule
bind mh_ctl mh_ctl_props i_props (.*);

// ### testbench/mh_dimm_model.sv
// behavioural pair of ecc modules answering read commands
// assumes commands stand one cycle; flip is the error pattern returned
`timescale 1ns/1ps
module mh_dimm_model #(
	parameter int LAT = 3
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_scrub,
	input wire logic [1:0] cmd_rank,
	input wire logic [143:0] flip,
	output logic rd_valid,
	output logic [143:0] rd_data,
	output logic [1:0] rd_row,
	output logic rd_scrub
);
	logic [3:0] pipe_r [LAT];
	logic tgl_r;
	// read latency pipe; writes are absorbed without an answer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pipe_r <= '{default: 4'h0};
			tgl_r <= 1'h0;
		end else begin
			pipe_r[0] <= {cmd_valid & ~cmd_write, cmd_scrub, cmd_rank};
			for (int i = 1; i < LAT; i++) pipe_r[i] <= pipe_r[i-1];
			tgl_r <= ~tgl_r;
		end
	end
	assign {rd_valid, rd_scrub, rd_row} = pipe_r[LAT-1];
	// stored words are zero codewords in both lanes, flip adds errors;
	// between reads the bus toggles so stale data never looks valid
	assign rd_data = rd_valid ? flip : {72{tgl_r, ~tgl_r}};
endmodule

// ### testbench/tb.sv
// self-checking bench for the memory hub control block
// assumes the ecc module model on the read side and the bound checker
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'h0, rstn = 1'h0, proc_bus_533 = 1'h0, cfg_done = 1'h0;
	logic cas_latency_setting = 1'h0, scrub_en = 1'h0, host_valid = 1'h0;
	logic host_write = 1'h0, out_ready = 1'h0, clr_single = 1'h0;
	logic clr_multi = 1'h0, rd_valid, rd_scrub, cas_sel_r, host_ready_r;
	logic cmd_valid_r, cmd_write_r, cmd_scrub_r, out_valid_r, out_write_r;
	logic rdq_valid_r, wb_valid_r, err_single_r, err_multi_r;
	logic err_single_evt_r, err_multi_evt_r;
	logic [1:0] pair_row13 = 2'h0, pair_dual_side = 2'h0, io_valid = 2'h0;
	logic [1:0] io_write = 2'h0, mem_clk_sel_r, pair_usable_r, cmd_bank_r;
	logic [1:0] rd_row, cmd_rank_r, io_ack_r, wb_rank_r, err_row_r;
	logic [3:0] slot_present = 4'h0, pair_col_sel = 4'h0, row_enable_r;
	logic [12:0] cmd_row_r, cmd_col_r;
	logic [35:0] host_addr = 36'h0, io0_addr = 36'h0, io1_addr = 36'h0;
	logic [35:0] out_addr_r;
	logic [36:0] mem_top_r;
	logic [143:0] rd_data, rdq_data_r, wb_data_r, flip = 144'h0;
	int n_errors = 0, checked = 0;
	// {bus533, cas, dual[1:0]}, slots, {00, usable}, rows enabled
	logic [15:0] rows [7] = '{16'hFF3F, 16'h0311, 16'h9313, 16'h6F3D,
		16'hBE2C, 16'h4711, 16'h3000};

	mh_ctl i_dut (.*);
	mh_dimm_model #(.LAT(3)) i_mem (.clk_sys, .rstn, .cmd_valid(cmd_valid_r),
		.cmd_write(cmd_write_r), .cmd_scrub(cmd_scrub_r),
		.cmd_rank(cmd_rank_r), .flip, .rd_valid, .rd_data, .rd_row, .rd_scrub);

	// free-running system clock
	always #5 clk_sys = ~clk_sys;

	// verdict and end of run
	task automatic stop_test();
		if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// value compare, four-state exact
	task automatic cmp(input logic [143:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	// bounded wait on a flag, sampled mid-cycle where it is settled
	task automatic wait_hi(ref logic s, input string what);
		int i;
		i = 0;
		do @(negedge clk_sys); while (s !== 1'h1 && ++i < 1200);
		cmp(s, 1'h1, what);
	endtask

	// one processor read, held until the edge that takes it
	task automatic host_req(input logic [35:0] a);
		@(posedge clk_sys);
		host_addr <= a;
		host_valid <= 1'h1;
		wait_hi(host_ready_r, "host ready");
		@(posedge clk_sys) host_valid <= 1'h0;
	endtask

	// read address zero back with the given error pattern
	task automatic ecc_case(input logic [143:0] m, input logic s, mu);
		flip <= m;
		host_req(36'h0);
		wait_hi(cmd_valid_r, "command");
		cmp({cmd_bank_r, cmd_row_r, cmd_col_r}, 28'h0, "decode");
		cmp(cmd_rank_r, 2'h0, "rank");
		wait_hi(rdq_valid_r, "read data");
		if (!mu) cmp(rdq_data_r, 144'h0, "corrected");
		cmp({err_single_evt_r, err_multi_evt_r}, {s, mu}, "event");
	endtask

	// watchdog well past the longest scrub wait
	initial begin
		#200us;
		n_errors++;
		stop_test();
	end

	// main sequence
	initial begin
		int w;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'h1;
		foreach (rows[k]) begin
			@(posedge clk_sys);
			{proc_bus_533, cas_latency_setting, pair_dual_side} <= rows[k][15:12];
			slot_present <= rows[k][11:8];
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys);
			cmp(mem_clk_sel_r, rows[k][15] ? 2'h1 : 2'h0, "clock");
			cmp(cas_sel_r, rows[k][14], "cas");
			cmp(pair_usable_r, rows[k][5:4], "pairs");
			cmp(row_enable_r, rows[k][3:0], "rows");
		end
		// firmware settles one map from eeprom data: both pairs
		// filled, matched modules, 128 MB per pair
		@(posedge clk_sys);
		{proc_bus_533, cas_latency_setting, pair_dual_side} <= 4'hC;
		slot_present <= 4'hF;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp(mem_top_r, 37'h010000000, "map top");
		@(posedge clk_sys);
		cfg_done <= 1'h1;
		ecc_case(144'h0, 1'h0, 1'h0);
		ecc_case(144'h1, 1'h1, 1'h0);
		ecc_case(144'h1 << 81, 1'h1, 1'h0);
		ecc_case(144'h28, 1'h0, 1'h1);
		cmp({err_single_r, err_multi_r}, 2'h3, "sticky");
		@(posedge clk_sys) clr_single <= 1'h1;
		@(posedge clk_sys) clr_single <= 1'h0;
		@(negedge clk_sys);
		cmp({err_single_r, err_multi_r}, 2'h1, "clear");
		cmp(err_row_r, 2'h0, "error row");
		// outbound sink stalls while twelve requests pile up
		for (int i = 0; i < 12; i++) host_req(36'hF00000000 + 36'(i * 16));
		@(negedge clk_sys);
		cmp(host_ready_r, 1'h0, "queue full");
		cmp({out_valid_r, out_addr_r}, 37'h1F00000000, "held head");
		@(posedge clk_sys) out_ready <= 1'h1;
		io0_addr <= 36'h40;
		io1_addr <= 36'h80;
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys) io_valid <= 2'h1 << p;
			w = 0;
			do @(negedge clk_sys); while (io_ack_r[p] !== 1'h1 && ++w < 50);
			cmp(io_ack_r, 2'h1 << p, "io ack");
			@(posedge clk_sys) io_valid <= 2'h0;
		end
		@(posedge clk_sys) scrub_en <= 1'h1;
		flip <= 144'h20;
		wait_hi(wb_valid_r, "scrub write-back");
		cmp(wb_data_r, 144'h0, "scrub fix");
		cmp(wb_rank_r, 2'h0, "scrub row");
		@(posedge clk_sys) rstn <= 1'h0;
		@(negedge clk_sys);
		cmp({pair_usable_r, host_ready_r, err_single_r}, 4'h0, "reset");
		stop_test();
	end
endmodule
